/* design/pgc_pkg.sv */
// general control register bank package: offsets, field layout, resets, timing
// assumes a 20 MHz core clock and an AHB-Lite master with whole-word accesses
// Operation
// - high fill threshold triggers pause frame
// - low fill threshold triggers resume frame
// - settings reset only on power good
// - fifo empty threshold drives management-mode flow control
// - store-wake-packet bit saves wake packet
// - use-wake-pin bit signals wake on pin
// - wake-pin clear bit deasserts pin, self-clears
// - legacy-wake bit selects native wake flows
// - jumbo filter and address cropping enables
// - no-capture bit decides wake without capture
// - oem mask suppresses oem, gigabit, renegotiate
// - release-disable blocks bus release on reset
// - multicast table reset scope selection
// - beacon enable turns on beacon signalling
// - k1 exit delayed by microsecond count
// - beacon gap is field times 50 ms
// - beacon length is field times 0.5 us
// - capability bit reports dual queues
// - other capability bits report features, default zero
package pgc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 50;
  localparam int K1_STEP_NS       = 1000;
  localparam int K1_STEP_CYC      = (K1_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BEACON_DURATION_STEP_NS  = 500;
  localparam int BEACON_DURATION_STEP_CYC = (BEACON_DURATION_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BCN_GAP_STEP_MS  = 50;
  localparam int BCN_GAP_STEP_CYC = BCN_GAP_STEP_MS * 1000000 / CLK_PERIOD_NS;

  // ****************************************************************
  // register map: index (byte address is four times), page
  // ****************************************************************
  localparam int          NUM_REGS      = 5;
  localparam int          R_CFG         = 0;
  localparam int          R_PAUSE       = 1;
  localparam int          R_WAKE        = 2;
  localparam int          R_MEM         = 3;
  localparam int          R_BCN         = 4;
  localparam logic [15:0] PAGE_GENERAL  = 16'h0304;
  localparam logic [15:0] PAGE_CAPAB    = 16'h0308;
  localparam logic [15:0] PAGE_OFFBOARD = 16'h030B;
  localparam logic [4:0]  IDX_CAPAB     = 5'h13;
  localparam logic [4:0]  IDX_PAGE_SEL  = 5'h1F;
  localparam logic [15:0] PAGE_SEL_RST  = PAGE_GENERAL;
  localparam logic [4:0]  REG_INDEX [NUM_REGS] = '{5'h14, 5'h18, 5'h19, 5'h1A, 5'h14};
  localparam logic [15:0] REG_PAGE  [NUM_REGS] =
    '{PAGE_GENERAL, PAGE_GENERAL, PAGE_GENERAL, PAGE_GENERAL, PAGE_OFFBOARD};
  localparam logic [15:0] REG_RST   [NUM_REGS] =
    '{16'hFF00, 16'h0000, 16'hD03A, 16'h2FFF, 16'h0142};
  localparam logic [15:0] REG_WMASK [NUM_REGS] =
    '{16'h0002, 16'hFFFF, 16'h1EFF, 16'h1010, 16'h8FFF};
  localparam logic [15:0] REG_AUTOCLR [NUM_REGS] =
    '{16'h0000, 16'h0000, 16'h0040, 16'h0000, 16'h0000};
  localparam logic [15:0] CAPAB_MASK = 16'h03F7;
  localparam logic [15:0] CAPAB_RST  = 16'h0000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PAUSE_HIGH_LSB = 0;
  localparam int PAUSE_LOW_LSB  = 8;
  localparam int WAKE_FIFO_LSB  = 0;
  localparam int WAKE_STORE     = 4;
  localparam int WAKE_USE_PIN   = 5;
  localparam int WAKE_CLR_PIN   = 6;
  localparam int WAKE_LEGACY    = 7;
  localparam int WAKE_FILT_1G   = 9;
  localparam int WAKE_CROP_MGMT = 10;
  localparam int WAKE_CROP_BC   = 11;
  localparam int WAKE_NO_CAP    = 12;
  localparam int MEM_OEM_MASK   = 12;
  localparam int MEM_REL_DIS    = 4;
  localparam int CFG_MTA_PGOOD  = 1;
  localparam int BCN_EN         = 15;
  localparam int BCN_REF_LSB    = 8;
  localparam int BEACON_INTERVAL_LSB  = 4;
  localparam int BEACON_DURATION_LSB    = 0;
  localparam int CAP_DUAL_Q     = 6;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } pgc_ahb_in_t;

  typedef enum logic [1:0] {BCN_IDLE, BCN_ON, BCN_GAP} pgc_bcn_state_t;

endpackage

/* design/pgc_regs.sv */
// general control register bank with the small engines its settings steer
// assumes one AHB-Lite master, same-clock datapath inputs, one async pin input
`timescale 1ns/1ps
module pgc_regs
  import pgc_pkg::*;
#(
  parameter int          BCN_GAP_CYC = BCN_GAP_STEP_CYC,
  parameter logic [15:0] CAPABILITY  = CAPAB_RST
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        soft_rst,
  input  wire pgc_ahb_in_t ahb_in,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [7:0]  buf_fill,
  output logic             xoff_req,
  output logic             xon_req,
  input  wire logic        mgmt_bus_mode,
  input  wire logic [3:0]  rx_fifo_level,
  output logic             smb_flow_pause,
  input  wire logic        wake_evt,
  input  wire logic        wake_captured,
  output logic             wake_pin_n,
  output logic             store_wake_packet,
  output logic             legacy_wake,
  output logic             filter_1g_jumbo,
  output logic             crop_mgmt_da,
  output logic             crop_bcast_da,
  input  wire logic        oem_lplu_in,
  input  wire logic        gig_disable_in,
  input  wire logic        restart_aneg_in,
  output logic             oem_lplu_eff,
  output logic             gig_disable_eff,
  output logic             restart_aneg_eff,
  input  wire logic        connected_device_reset,
  output logic             mgmt_bus_release,
  output logic             multicast_table_clear,
  input  wire logic        k1_exit_req,
  output logic             k1_exit_go,
  output logic             beacon_out
);

  // ****************************************************************
  // bus slave: address phase capture
  // ****************************************************************
  logic        dp_write;
  logic        dp_read;
  logic        dp_ok;
  logic [4:0]  dp_idx;
  logic [15:0] page_sel;
  logic [15:0] bank [NUM_REGS];

  // word-aligned addresses inside the 32-word window only, any hsize; others read zero
  wire         ap_take = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
  wire         ap_ok   = (ahb_in.haddr[1:0] == 2'h0) & (ahb_in.haddr[31:7] == 25'h0);
  wire [4:0]   ap_idx  = ahb_in.haddr[6:2];
  wire         wr_en   = dp_write & dp_ok;
  wire [15:0]  wdata   = ahb_in.hwdata[15:0];

  // data-phase tracking; reads cost one wait so earlier writes have landed
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_ok    <= 1'b0;
      dp_idx   <= 5'h00;
    end else begin
      dp_write <= ap_take & ahb_in.hwrite;
      dp_read  <= ap_take & ~ahb_in.hwrite;
      if (ap_take) begin
        dp_ok  <= ap_ok;
        dp_idx <= ap_idx;
      end
    end
  end

  // ****************************************************************
  // register bank
  // ****************************************************************
  logic [NUM_REGS-1:0] wr_hit;
  logic [15:0]         rd_term [NUM_REGS];

  // one entry per register; only power-good clears them, soft_rst never does
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    wire sel = (dp_idx == REG_INDEX[i]) & (page_sel == REG_PAGE[i]);
    assign wr_hit[i]  = wr_en & sel;
    assign rd_term[i] = sel ? bank[i] : 16'h0000;
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        bank[i] <= REG_RST[i];
      end else if (wr_hit[i]) begin
        bank[i] <= (wdata & REG_WMASK[i]) | (REG_RST[i] & ~REG_WMASK[i]);
      end else begin
        bank[i] <= bank[i] & ~REG_AUTOCLR[i];
      end
    end
  end

  // page select steers which bank the shared indices reach
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      page_sel <= PAGE_SEL_RST;
    end else if (wr_en & (dp_idx == IDX_PAGE_SEL)) begin
      page_sel <= wdata;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  wire        cap_sel  = (dp_idx == IDX_CAPAB) & (page_sel == PAGE_CAPAB);
  wire [15:0] cap_word = CAPABILITY & CAPAB_MASK;
  logic [15:0] rd_mux;

  // or of the one-hot terms; a miss leaves zero
  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd_mux = rd_mux | rd_term[i];
    end
    if (cap_sel) begin
      rd_mux = rd_mux | cap_word;
    end
    if (dp_idx == IDX_PAGE_SEL) begin
      rd_mux = rd_mux | page_sel;
    end
    if (!dp_ok) begin
      rd_mux = 16'h0000;
    end
  end

  // answer: reads stall one cycle, writes never stall, always okay
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (dp_read & ~hreadyout) begin
      hreadyout <= 1'b1;
      hrdata    <= {16'h0000, rd_mux};
    end else if (ap_take & ~ahb_in.hwrite) begin
      hreadyout <= 1'b0;
    end
  end

  // ****************************************************************
  // field views
  // ****************************************************************
  wire [7:0] high_fill_threshold = bank[R_PAUSE][PAUSE_HIGH_LSB +: 8];
  wire [7:0] low_fill_threshold  = bank[R_PAUSE][PAUSE_LOW_LSB +: 8];
  wire [3:0] fifo_empty_thr      = bank[R_WAKE][WAKE_FIFO_LSB +: 4];
  wire [3:0] refclk_wait_delay   = bank[R_BCN][BCN_REF_LSB +: 4];
  wire [3:0] beacon_interval     = bank[R_BCN][BEACON_INTERVAL_LSB +: 4];
  wire [3:0] beacon_duration     = bank[R_BCN][BEACON_DURATION_LSB +: 4];
  wire       beacon_enable       = bank[R_BCN][BCN_EN];
  wire       oem_bits_mask       = bank[R_MEM][MEM_OEM_MASK];

  // plain configuration levels go straight out of the bank flops
  assign store_wake_packet = bank[R_WAKE][WAKE_STORE];
  assign legacy_wake       = bank[R_WAKE][WAKE_LEGACY];
  assign filter_1g_jumbo   = bank[R_WAKE][WAKE_FILT_1G];
  assign crop_mgmt_da      = bank[R_WAKE][WAKE_CROP_MGMT];
  assign crop_bcast_da     = bank[R_WAKE][WAKE_CROP_BC];

  // ****************************************************************
  // flow control
  // ****************************************************************
  logic paused;
  // a zero high threshold leaves pause generation off
  wire  fc_en    = high_fill_threshold != 8'h00;
  wire  hit_high = fc_en & ~paused & (buf_fill >= high_fill_threshold);
  wire  hit_low  = paused & (buf_fill <= low_fill_threshold);

  // hysteresis: one pause per crossing, one resume when drained
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      paused         <= 1'b0;
      xoff_req       <= 1'b0;
      xon_req        <= 1'b0;
      smb_flow_pause <= 1'b0;
    end else begin
      xoff_req       <= hit_high;
      xon_req        <= hit_low;
      paused         <= (paused & ~hit_low & fc_en) | hit_high;
      smb_flow_pause <= mgmt_bus_mode & (rx_fifo_level >= fifo_empty_thr);
    end
  end

  // ****************************************************************
  // wake pin
  // ****************************************************************
  wire set_wake = wake_evt & bank[R_WAKE][WAKE_USE_PIN]
                & (wake_captured | bank[R_WAKE][WAKE_NO_CAP]);
  wire clr_wake = wr_hit[R_WAKE] & wdata[WAKE_CLR_PIN];

  // a wake arriving with the clear write wins, so no event is lost
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_pin_n <= 1'b1;
    end else if (set_wake) begin
      wake_pin_n <= 1'b0;
    end else if (clr_wake) begin
      wake_pin_n <= 1'b1;
    end
  end

  // ****************************************************************
  // oem mask, bus release, multicast reset scope
  // ****************************************************************
  logic cdr_meta;
  logic cdr_sync;
  logic cdr_prev;
  wire  cdr_pulse = cdr_sync & ~cdr_prev;

  // pin synchroniser; only the second stage feeds the edge detect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cdr_meta <= 1'b0;
      cdr_sync <= 1'b0;
      cdr_prev <= 1'b0;
    end else begin
      cdr_meta <= connected_device_reset;
      cdr_sync <= cdr_meta;
      cdr_prev <= cdr_sync;
    end
  end

  // masked controls read as zero; table clear held high through power good
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      oem_lplu_eff          <= 1'b0;
      gig_disable_eff       <= 1'b0;
      restart_aneg_eff      <= 1'b0;
      mgmt_bus_release      <= 1'b0;
      multicast_table_clear <= 1'b1;
    end else begin
      oem_lplu_eff          <= oem_lplu_in & ~oem_bits_mask;
      gig_disable_eff       <= gig_disable_in & ~oem_bits_mask;
      restart_aneg_eff      <= restart_aneg_in & ~oem_bits_mask;
      mgmt_bus_release      <= cdr_pulse & ~bank[R_MEM][MEM_REL_DIS];
      multicast_table_clear <= soft_rst & ~bank[R_CFG][CFG_MTA_PGOOD];
    end
  end

  // ****************************************************************
  // k1 exit delay
  // ****************************************************************
  logic        k1_wait;
  logic [15:0] k1_cnt;
  wire  [15:0] k1_load = 16'(refclk_wait_delay * K1_STEP_CYC);

  // further requests while waiting are absorbed into the running delay
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      k1_wait    <= 1'b0;
      k1_cnt     <= 16'h0000;
      k1_exit_go <= 1'b0;
    end else if (k1_wait) begin
      k1_exit_go <= k1_cnt <= 16'h0001;
      k1_wait    <= k1_cnt > 16'h0001;
      k1_cnt     <= k1_cnt - 16'h0001;
    end else begin
      k1_exit_go <= 1'b0;
      k1_wait    <= k1_exit_req;
      k1_cnt     <= k1_load;
    end
  end

  // ****************************************************************
  // beacon generator
  // ****************************************************************
  pgc_bcn_state_t bcn_state;
  logic [23:0]    bcn_cnt;
  wire  [23:0]    on_load  = 24'(beacon_duration * BEACON_DURATION_STEP_CYC);
  wire  [23:0]    gap_load = 24'(beacon_interval * BCN_GAP_CYC);
  // zero fields are illegal; they degrade to one-cycle phases, no lockup
  wire            bcn_done = bcn_cnt <= 24'h00_0001;

  // off, high for the duration, low for the interval, repeat
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !beacon_enable) begin
      bcn_state  <= BCN_IDLE;
      bcn_cnt    <= 24'h00_0000;
      beacon_out <= 1'b0;
    end else begin
      unique case (bcn_state)
        BCN_IDLE: begin
          bcn_state  <= BCN_ON;
          bcn_cnt    <= on_load;
          beacon_out <= 1'b1;
        end
        BCN_ON: begin
          bcn_cnt <= bcn_done ? gap_load : bcn_cnt - 24'h00_0001;
          if (bcn_done) begin
            bcn_state  <= BCN_GAP;
            beacon_out <= 1'b0;
          end
        end
        BCN_GAP: begin
          bcn_cnt <= bcn_done ? on_load : bcn_cnt - 24'h00_0001;
          if (bcn_done) begin
            bcn_state  <= BCN_ON;
            beacon_out <= 1'b1;
          end
        end
        default: begin
          bcn_state <= BCN_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // the go pulse is launched at the end of the count and sampled one edge later
  localparam int A_K1 = K1_STEP_CYC + 1;
  logic [7:0] a_high_len;

  // counts high cycles of the beacon for the duration check
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !beacon_out) begin
      a_high_len <= 8'h00;
    end else begin
      a_high_len <= a_high_len + 8'h01;
    end
  end

  default clocking a_clk @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_xoff_cause;
    xoff_req |-> $past(buf_fill) >= $past(high_fill_threshold)
      && $past(high_fill_threshold) != 8'h00;
  endproperty
  a_xoff_cause: assert property (p_xoff_cause) else $error("pause without high fill");

  property p_xon_after_xoff;
    xon_req |-> $past(paused) && !paused && $past(buf_fill) <= $past(low_fill_threshold);
  endproperty
  a_xon_after_xoff: assert property (p_xon_after_xoff) else $error("resume without pause");

  property p_soft_keeps;
    soft_rst && !wr_en |=> $stable(bank[R_PAUSE]) && $stable(bank[R_MEM]);
  endproperty
  a_soft_keeps: assert property (p_soft_keeps) else $error("soft reset touched settings");

  property p_clear_pin;
    clr_wake && !set_wake |=> wake_pin_n ##1 !bank[R_WAKE][WAKE_CLR_PIN];
  endproperty
  a_clear_pin: assert property (p_clear_pin) else $error("wake clear failed");

  property p_no_capture;
    wake_evt && !wake_captured && !bank[R_WAKE][WAKE_NO_CAP] && wake_pin_n |=> wake_pin_n;
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("wake without capture");

  property p_wake_set;
    wake_evt && wake_captured && bank[R_WAKE][WAKE_USE_PIN] |=> !wake_pin_n;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake pin not asserted");

  property p_oem_mask;
    oem_bits_mask |=> !gig_disable_eff && !restart_aneg_eff && !oem_lplu_eff;
  endproperty
  a_oem_mask: assert property (p_oem_mask) else $error("masked control leaked");

  property p_release;
    mgmt_bus_release |-> $past(cdr_pulse) && !$past(bank[R_MEM][MEM_REL_DIS]);
  endproperty
  a_release: assert property (p_release) else $error("bus release not allowed");

  property p_mta_scope;
    soft_rst |=> multicast_table_clear == !$past(bank[R_CFG][CFG_MTA_PGOOD]);
  endproperty
  a_mta_scope: assert property (p_mta_scope) else $error("table clear scope wrong");

  property p_k1_one_us;
    k1_exit_req && !k1_wait && refclk_wait_delay == 4'h1 |-> ##[A_K1:A_K1] k1_exit_go;
  endproperty
  a_k1_one_us: assert property (p_k1_one_us) else $error("k1 delay wrong");

  property p_beacon_len;
    $fell(beacon_out) && beacon_enable && $stable(beacon_duration)
      |-> 32'(a_high_len) == 32'(beacon_duration) * BEACON_DURATION_STEP_CYC;
  endproperty
  a_beacon_len: assert property (p_beacon_len) else $error("beacon length wrong");

endmodule

/* testbench/pgc_host_model.sv */
// host-side model of the management master speaking AHB-Lite
// assumes the slave's hreadyout is looped back as hready
`timescale 1ns/1ps
module pgc_host_model
  import pgc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output pgc_ahb_in_t      ahb
);
  pgc_ahb_in_t req = '0;

  // hready comes from the slave, not from this master
  assign ahb = '{req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, req.hwdata, hready};

  // one single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge sys_clk);
    req <= '{1'b1, a, 2'b10, w, 3'b010, req.hwdata, 1'b0};
    do @(posedge sys_clk); while (hready !== 1'b1);
    req.hsel   <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= {16'h0000, d};
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata[15:0];
  endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the general control register bank
// assumes pgc_regs with a shortened beacon gap and the host model
`timescale 1ns/1ps
module tb_top
  import pgc_pkg::*;
();
  logic        sys_clk = 0, sys_rst = 1, soft_rst = 0, mode = 0, wevt = 0, wcap = 0;
  logic        cdr = 0, k1_req = 0, oem_in = 0, gig_in = 0, aneg_in = 0;
  logic [7:0]  buf_fill = 0;
  logic [3:0]  fifo_lvl = 0;
  logic        rdy, xoff, xon, smb_p, pin_n, store, legacy, filt, crop_m, crop_b;
  logic        oem_e, gig_e, aneg_e, rel, multicast_table, k1_go, bcn, resp;
  logic [31:0] hrdata;
  pgc_ahb_in_t ahb_in;
  int          mismatches = 0, total_checks = 0, n_xoff = 0, n_xon = 0, n_rel = 0, n_go = 0;

  initial forever #25 sys_clk = ~sys_clk;

  // pulse tallies; scenarios compare differences
  always @(posedge sys_clk) begin
    n_xoff <= n_xoff + xoff;
    n_xon  <= n_xon + xon;
    n_rel  <= n_rel + rel;
    n_go   <= n_go + k1_go;
  end

  pgc_host_model host (.sys_clk(sys_clk), .hready(rdy), .hrdata(hrdata), .ahb(ahb_in));

  pgc_regs #(.BCN_GAP_CYC(50), .CAPABILITY(16'h0040)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .soft_rst(soft_rst), .ahb_in(ahb_in),
    .hreadyout(rdy), .hrdata(hrdata), .hresp(resp), .buf_fill(buf_fill),
    .xoff_req(xoff), .xon_req(xon), .mgmt_bus_mode(mode), .rx_fifo_level(fifo_lvl),
    .smb_flow_pause(smb_p), .wake_evt(wevt), .wake_captured(wcap), .wake_pin_n(pin_n),
    .store_wake_packet(store), .legacy_wake(legacy), .filter_1g_jumbo(filt),
    .crop_mgmt_da(crop_m), .crop_bcast_da(crop_b), .oem_lplu_in(oem_in),
    .gig_disable_in(gig_in), .restart_aneg_in(aneg_in), .oem_lplu_eff(oem_e),
    .gig_disable_eff(gig_e), .restart_aneg_eff(aneg_e), .connected_device_reset(cdr),
    .mgmt_bus_release(rel), .multicast_table_clear(multicast_table), .k1_exit_req(k1_req),
    .k1_exit_go(k1_go), .beacon_out(bcn));

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [15:0] q;
    host.xfer(1'b1, a, d, q);
    // the write lands at the last edge; registered views need one more
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [15:0] e, input string m);
    logic [15:0] q;
    host.xfer(1'b0, a, 16'h0000, q);
    chk(q, e, m);
  endtask

  task automatic wake(input logic cap);
    @(posedge sys_clk);
    wevt <= 1'b1;
    wcap <= cap;
    @(posedge sys_clk);
    wevt <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults();
    rd(32'h50, 16'hFF00, "cfg");
    rd(32'h60, 16'h0000, "pause");
    rd(32'h64, 16'hD03A, "wake");
    rd(32'h68, 16'h2FFF, "mem");
    chk({store, pin_n, multicast_table, resp}, 4'b1100, "pins");
    wr(32'h7C, 16'h0308);
    wr(32'h4C, 16'hFFFF);
    rd(32'h4C, 16'h0040, "cap");
    rd(32'h40, 16'h0000, "unmapped");
    $display("test defaults done");
  endtask

  task automatic t_masks();
    wr(32'h7C, 16'h0304);
    wr(32'h50, 16'hFFFF);
    rd(32'h50, 16'hFF02, "cfg wmask");
    wr(32'h64, 16'hFFFF);
    rd(32'h64, 16'hDEBF, "wake wmask");
    chk({legacy, filt, crop_m, crop_b}, 4'hF, "wake opts");
    wr(32'h64, 16'hD03A);
    chk({legacy, filt}, 2'b00, "wake opts off");
    @(posedge sys_clk) soft_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(multicast_table, 1'b0, "mta pgood only");
    wr(32'h50, 16'h0000);
    repeat (2) @(posedge sys_clk);
    chk(multicast_table, 1'b1, "mta on reset");
    soft_rst <= 1'b0;
    rd(32'h64, 16'hD03A, "soft keeps");
    $display("test masks done");
  endtask

  task automatic t_flow();
    int b0, b1;
    wr(32'h60, 16'h0408);
    rd(32'h60, 16'h0408, "thr");
    b0 = n_xoff;
    b1 = n_xon;
    buf_fill <= 8'd8;
    repeat (4) @(posedge sys_clk);
    chk(16'(n_xoff - b0), 1, "xoff");
    buf_fill <= 8'd5;
    repeat (4) @(posedge sys_clk);
    chk(16'(n_xon - b1), 0, "early xon");
    buf_fill <= 8'd4;
    repeat (4) @(posedge sys_clk);
    chk(16'(n_xon - b1), 1, "xon");
    mode     <= 1'b1;
    fifo_lvl <= 4'd10;
    repeat (3) @(posedge sys_clk);
    chk(smb_p, 1'b1, "smb pause");
    fifo_lvl <= 4'd9;
    repeat (3) @(posedge sys_clk);
    chk(smb_p, 1'b0, "smb run");
    $display("test flow done");
  endtask

  task automatic t_wake();
    wake(1'b0);
    chk(pin_n, 1'b0, "wake nocap");
    wr(32'h64, 16'hD07A);
    chk(pin_n, 1'b1, "pin cleared");
    rd(32'h64, 16'hD03A, "clr self");
    wr(32'h64, 16'hC03A);
    wake(1'b0);
    chk(pin_n, 1'b1, "no wake");
    wake(1'b1);
    chk(pin_n, 1'b0, "wake cap");
    wr(32'h64, 16'hC07A);
    $display("test wake done");
  endtask

  task automatic t_oem_rel();
    int b;
    {oem_in, gig_in, aneg_in} <= 3'b111;
    wr(32'h68, 16'hFFFF);
    chk({oem_e, gig_e, aneg_e}, 3'b000, "masked");
    b = n_rel;
    cdr <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(16'(n_rel - b), 0, "rel blocked");
    cdr <= 1'b0;
    wr(32'h68, 16'h2FEF);
    chk({oem_e, gig_e, aneg_e}, 3'b111, "unmasked");
    cdr <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(16'(n_rel - b), 1, "rel");
    $display("test oem release done");
  endtask

  task automatic t_beacon();
    int n, b;
    wr(32'h7C, 16'h030B);
    wr(32'h50, 16'h8112);
    n = 0;
    while (bcn !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (bcn === 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk(16'(n), 20, "beacon on");
    n = 0;
    while (bcn === 1'b0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk(16'(n), 50, "beacon gap");
    wr(32'h50, 16'h0112);
    repeat (2) @(posedge sys_clk);
    chk(bcn, 1'b0, "beacon off");
    b = n_go;
    k1_req <= 1'b1;
    @(posedge sys_clk) k1_req <= 1'b0;
    repeat (17) @(posedge sys_clk);
    chk(16'(n_go - b), 0, "k1 early");
    repeat (6) @(posedge sys_clk);
    chk(16'(n_go - b), 1, "k1 go");
    $display("test beacon k1 done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: the sequence needs a few hundred cycles
  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_defaults();
    t_masks();
    t_flow();
    t_wake();
    t_oem_rel();
    t_beacon();
    print_verdict();
  end
endmodule
